// ==== ccg_clock_gen.sv ====
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
// How it works
// [R1] Shortest instruction lasts two CPU clocks
// [R2] Main ratios 0.4-12.8us, subsystem about 122us
// [R3] Mode register picks raw or divided oscillator
// [R4] Bypass select is mode register bit 0
// [R5] Mode register written as whole byte only
// [R6] Mode write stretches main clock two periods
// [R7] Write mode register only after reset
// [R8] Software writes zero to control bit 3
// [R9] Reset loads control 04H, mode 00H
// [R10] Main oscillation halted while reset low
// [R11] STOP and HALT available on main clock
// [R12] Bit 6 disconnects subsystem feedback resistor
// [R13] Subsystem: HALT only, never stopped
// [R14] Subsystem clock to timer, watch, clock out
// [R15] Other peripherals from divided main clock
// [R16] Divider feeds CPU selection and peripherals
// [R17] Status 0: ratio bits pick CPU speed
// [R18] Main stop acts only after status 1
// [R19] External main clock: no STOP, no stop
// [R20] Control register bit/byte access, fields
// [R21] Ratio codes 0-4 divide; source 1 halves
// [R22] Old clock runs several instructions after write
// [R23] CPU clock switch glitch-free
// [R24] Status changes when clock actually moved
module ccg_clock_gen
  import ccg_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       main_osc_tick_in,
  input  wire logic       sub_osc_in,
  input  wire logic       wake_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] bit_mask_in,
  output logic [7:0]      rdata_out,
  output logic            main_osc_enable_out,
  output logic            feedback_resistor_disable_out,
  output logic            main_sys_tick_out,
  output logic            cpu_tick_out,
  output logic            cpu_run_out,
  output logic [4:0]      periph_tick_out,
  output logic            sub_periph_tick_out,
  output logic            halt_out,
  output logic            stop_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]      proc_clock_ctrl_reg;
  logic [7:0]      oscillation_mode_select_reg;
  logic [7:0]      rdata_reg;
  logic [2:0]      sub_sync_reg;
  logic            sub_level_reg;
  logic            sub_half_reg;
  logic [4:0]      div_cnt_reg;
  logic            half_reg;
  logic [1:0]      stretch_reg;
  logic [2:0]      div_act_reg;
  logic            src_act_reg;
  logic [4:0]      sw_cnt_reg;
  logic            cpu_phase_reg;
  logic            status_reg;
  ccg_mode_e       mode_reg;
  ccg_mode_e       mode_next;
  logic [4:0]      periph_reg;
  logic            sub_periph_reg;
  logic            main_tick_reg;
  logic            cpu_tick_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic hit_pcc   = (addr_in == PROC_CLK_CTRL_ADDR);
  wire logic hit_oscillation_mode_select  = (addr_in == OSC_MODE_SEL_ADDR);
  wire logic hit_stby  = (addr_in == STANDBY_CMD_ADDR);
  wire logic wr_pcc    = wr_in && hit_pcc;
  wire logic wr_oscillation_mode_select   = wr_in && hit_oscillation_mode_select;
  wire logic wr_stby   = wr_in && hit_stby;

  // Bit manipulation merges through the mask; full byte uses 8'hFF.
  // Status bit is read only and bit 3 is forced to zero.
  wire logic [7:0] pcc_merged =
    (proc_clock_ctrl_reg & ~bit_mask_in) | (wdata_in & bit_mask_in); // R20
  wire logic [7:0] pcc_wr_val = {pcc_merged[MAIN_OSC_STOP_BIT],
                                 pcc_merged[FB_RES_DIS_BIT],
                                 1'b0,
                                 pcc_merged[SRC_SEL_BIT],
                                 1'b0,
                                 pcc_merged[DIV_SEL_HI:0]}; // R8

  // ----------------------------------------------------------------
  // Subsystem clock input synchroniser
  // ----------------------------------------------------------------
  wire logic sub_agree = (sub_sync_reg[1] == sub_sync_reg[2]);
  wire logic sub_rise  = sub_agree && sub_sync_reg[2] && !sub_level_reg;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sub_sync_reg  <= 3'h0;
      sub_level_reg <= 1'b0;
      sub_half_reg  <= 1'b0;
    end else begin
      sub_sync_reg <= {sub_sync_reg[1:0], sub_osc_in};
      if (sub_agree) begin
        sub_level_reg <= sub_sync_reg[2];
      end
      if (sub_rise) begin
        sub_half_reg <= ~sub_half_reg;
      end
    end
  end

  // Subsystem never stops, even in STOP
  wire logic sub_tick      = sub_rise; // R13
  wire logic sub_half_tick = sub_rise && sub_half_reg; // R21

  // ----------------------------------------------------------------
  // Main system clock: raw or halved, with write stretch
  // ----------------------------------------------------------------
  wire logic osc_stop_req = proc_clock_ctrl_reg[MAIN_OSC_STOP_BIT]
                            && status_reg; // R18
  wire logic osc_running  = !osc_stop_req && (mode_reg != CCG_STOP);
  wire logic osc_tick     = main_osc_tick_in && osc_running;
  wire logic bypass       =
    oscillation_mode_select_reg[BYPASS_SEL_BIT]; // R4
  // A pending stretch swallows oscillator periods on every mode write
  wire logic stretching   = (stretch_reg != 2'h0); // R6
  wire logic main_tick    = osc_tick && !stretching &&
                            (bypass || half_reg); // R3

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      half_reg    <= 1'b0;
      stretch_reg <= 2'h0;
    end else begin
      if (osc_tick) begin
        half_reg <= ~half_reg;
      end
      if (wr_oscillation_mode_select) begin
        stretch_reg <= STRETCH_CYCLES; // R6
      end else if (stretching && osc_tick) begin
        stretch_reg <= stretch_reg - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  logic [DIV_STAGES-1:0] stage_tick;

  // Stage n ticks once per 2^n main clocks
  generate
    for (genvar i = 0; i < DIV_STAGES; i++) begin : g_div
      if (i == 0) begin : g_first
        assign stage_tick[i] = main_tick; // R2
      end else begin : g_rest
        assign stage_tick[i] = main_tick && (&div_cnt_reg[i-1:0]); // R16
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_reg <= 5'h00;
    end else if (main_tick) begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // CPU clock selection with delayed switchover
  // ----------------------------------------------------------------
  wire logic [2:0] div_req  = proc_clock_ctrl_reg[DIV_SEL_HI:0];
  wire logic       src_req  = proc_clock_ctrl_reg[SRC_SEL_BIT];
  wire logic [2:0] div_safe = (div_req > DIV_MAX_CODE) ? DIV_MAX_CODE
                                                       : div_req; // R21
  wire logic       main_cpu = stage_tick[div_act_reg]; // R17
  wire logic       cpu_tick;
  wire logic       on_sub;

  ccg_glitch_mux u_mux (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .sel_in    (src_act_reg),
    .tick_a_in (main_cpu),
    .tick_b_in (sub_half_tick),
    .tick_out  (cpu_tick),
    .on_b_out  (on_sub)
  ); // R23

  wire logic sel_diff = (div_safe != div_act_reg) ||
                        (src_req != src_act_reg);
  // Delay count used up: the new selection may take over
  wire logic sw_done  = (sw_cnt_reg == 5'h00);
  // Move only at an instruction boundary of the current clock
  wire logic instr_end = cpu_tick && cpu_phase_reg; // R1

  // Old setting holds for a few instructions after a write; the
  // divider index only moves on a slow stage edge so no runt period
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_act_reg   <= PROC_CLK_CTRL_RESET[DIV_SEL_HI:0]; // R9
      src_act_reg   <= 1'b0;
      sw_cnt_reg    <= 5'h00;
      cpu_phase_reg <= 1'b0;
    end else begin
      if (cpu_tick) begin
        cpu_phase_reg <= ~cpu_phase_reg;
      end
      if (wr_pcc) begin
        sw_cnt_reg <= SWITCH_DELAY_CLKS; // R22
      end else if (sel_diff && instr_end && !sw_done) begin
        sw_cnt_reg <= sw_cnt_reg - 5'h01;
      end
      // Source and ratio move on their own boundaries; needing both in
      // one cycle would never come for some ratios and hang the switch
      if (sw_done && !wr_pcc && instr_end) begin
        src_act_reg <= src_req; // R22
      end
      // Every stage ends a period on the slowest stage edge: no runt
      if (sw_done && !wr_pcc && stage_tick[DIV_STAGES-1]) begin
        div_act_reg <= div_safe; // R23
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby modes
  // ----------------------------------------------------------------
  wire logic stop_req = wr_stby && wdata_in[STOP_CMD_BIT] && !status_reg;
  wire logic halt_req = wr_stby && wdata_in[HALT_CMD_BIT];

  // STOP on main clock only; subsystem allows HALT only
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      CCG_RUN: begin
        if (stop_req) begin
          mode_next = CCG_STOP; // R11
        end else if (halt_req) begin
          mode_next = CCG_HALT; // R13
        end
      end
      CCG_HALT: begin
        if (wake_in) begin
          mode_next = CCG_RUN;
        end
      end
      CCG_STOP: begin
        if (wake_in) begin
          mode_next = CCG_RUN;
        end
      end
      default: begin
        mode_next = CCG_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  wire logic [7:0] pcc_read = {proc_clock_ctrl_reg[7:6], status_reg,
                               proc_clock_ctrl_reg[4:0]};
  // Standby status: bit 1 in STOP, bit 0 in HALT
  wire logic [7:0] stby_read = {6'h00, mode_reg == CCG_STOP,
                                mode_reg == CCG_HALT};
  logic [7:0]      rd_value;

  // Read selection; unmapped addresses read as zero
  always_comb begin
    if (hit_pcc) begin
      rd_value = pcc_read;
    end else if (hit_oscillation_mode_select) begin
      rd_value = oscillation_mode_select_reg;
    end else if (hit_stby) begin
      rd_value = stby_read;
    end else begin
      rd_value = 8'h00;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      proc_clock_ctrl_reg         <= PROC_CLK_CTRL_RESET; // R9
      oscillation_mode_select_reg <= OSC_MODE_SEL_RESET; // R9
      status_reg                  <= 1'b0;
      mode_reg                    <= CCG_RUN;
      rdata_reg                   <= 8'h00;
    end else begin
      if (wr_pcc) begin
        proc_clock_ctrl_reg <= pcc_wr_val;
      end
      // Whole byte only; the mask is ignored here
      if (wr_oscillation_mode_select) begin
        oscillation_mode_select_reg <= wdata_in; // R5
      end
      status_reg <= on_sub; // R24
      mode_reg   <= mode_next;
      if (rd_in) begin
        rdata_reg <= rd_value;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // Peripheral strobes from the divider and subsystem clock
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      periph_reg     <= 5'h00;
      sub_periph_reg <= 1'b0;
      main_tick_reg  <= 1'b0;
      cpu_tick_reg   <= 1'b0;
    end else begin
      periph_reg     <= stage_tick; // R15
      sub_periph_reg <= sub_tick; // R14
      main_tick_reg  <= main_tick;
      cpu_tick_reg   <= cpu_tick && (mode_reg == CCG_RUN);
    end
  end

  // Main oscillator enable is low while reset is asserted
  assign main_osc_enable_out           = osc_running && arst_n_in; // R10
  assign feedback_resistor_disable_out =
    proc_clock_ctrl_reg[FB_RES_DIS_BIT]; // R12
  assign rdata_out           = rdata_reg;
  assign main_sys_tick_out   = main_tick_reg;
  assign cpu_tick_out        = cpu_tick_reg;
  assign cpu_run_out         = (mode_reg == CCG_RUN);
  assign periph_tick_out     = periph_reg;
  assign sub_periph_tick_out = sub_periph_reg;
  assign halt_out            = (mode_reg == CCG_HALT);
  assign stop_out            = (mode_reg == CCG_STOP);

endmodule

// ==== ccg_clock_gen_properties.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checks for the clock generator
// ------------------------------------------------------------
module ccg_clock_gen_checker
  import ccg_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       main_osc_tick_in,
  input wire logic       sub_osc_in,
  input wire logic       wake_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] bit_mask_in,
  input wire logic [7:0] rdata_out,
  input wire logic       main_osc_enable_out,
  input wire logic       feedback_resistor_disable_out,
  input wire logic       main_sys_tick_out,
  input wire logic       cpu_tick_out,
  input wire logic       cpu_run_out,
  input wire logic [4:0] periph_tick_out,
  input wire logic       sub_periph_tick_out,
  input wire logic       halt_out,
  input wire logic       stop_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Control register read decode
  wire ctrl_rd = rd_in && (addr_in == PROC_CLK_CTRL_ADDR);

  chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  chk_fb_follow: assert property (ctrl_rd |=>
    rdata_out[FB_RES_DIS_BIT] == $past(feedback_resistor_disable_out))
    else $error("resistor output differs from register");
  chk_zero_bit: assert property (ctrl_rd |=> !rdata_out[ZERO_BIT])
    else $error("control bit 3 reads one");
  // Reset itself is the cause here, so no disable
  chk_osc_reset: assert property (disable iff (1'b0)
    !arst_n_in |-> !main_osc_enable_out)
    else $error("main oscillator enabled in reset");
  chk_stop_osc: assert property (stop_out |-> !main_osc_enable_out)
    else $error("main oscillator runs in stop");
  chk_halt_cpu: assert property (!cpu_run_out &&
    !$past(cpu_run_out) |-> !cpu_tick_out)
    else $error("cpu tick while not running");
  chk_sub_route: assert property ($rose(sub_osc_in) |->
    ##[2:6] sub_periph_tick_out)
    else $error("subsystem tick missing");
  chk_div_space: assert property (periph_tick_out[4] |=>
    !periph_tick_out[4] [*8])
    else $error("divide by 16 tick too close");
  chk_mode_onehot: assert property
    ($onehot({cpu_run_out, halt_out, stop_out}))
    else $error("operating mode not one hot");
  // Main scenarios reached
  cover property (halt_out && sub_periph_tick_out);
  cover property (stop_out);
  cover property (cpu_tick_out && !main_osc_enable_out);
endmodule

bind ccg_clock_gen ccg_clock_gen_checker i_ccg_clock_gen_checker (
  .clk_in(clk_in), .arst_n_in(arst_n_in),
  .main_osc_tick_in(main_osc_tick_in), .sub_osc_in(sub_osc_in),
  .wake_in(wake_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .bit_mask_in(bit_mask_in),
  .rdata_out(rdata_out), .main_osc_enable_out(main_osc_enable_out),
  .feedback_resistor_disable_out(feedback_resistor_disable_out),
  .main_sys_tick_out(main_sys_tick_out), .cpu_tick_out(cpu_tick_out),
  .cpu_run_out(cpu_run_out), .periph_tick_out(periph_tick_out),
  .sub_periph_tick_out(sub_periph_tick_out), .halt_out(halt_out),
  .stop_out(stop_out));

// ==== ccg_glitch_mux.sv ====
`timescale 1ns/10ps
// Glitch-free two-input clock enable switch
module ccg_glitch_mux (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic sel_in,
  input  wire logic tick_a_in,
  input  wire logic tick_b_in,
  output logic      tick_out,
  output logic      on_b_out
);

  logic on_a_reg;
  logic on_b_reg;

  // Hand over only at a period boundary of the old source, and arm the new
  // source only after the old one has released, so no short phase appears
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      on_a_reg <= 1'b1;
      on_b_reg <= 1'b0;
    end else begin
      if (on_a_reg && sel_in && tick_a_in) begin
        on_a_reg <= 1'b0;
      end else if (!on_a_reg && !sel_in && !on_b_reg) begin
        on_a_reg <= 1'b1;
      end
      if (on_b_reg && !sel_in && tick_b_in) begin
        on_b_reg <= 1'b0;
      end else if (!on_b_reg && sel_in && !on_a_reg) begin
        on_b_reg <= 1'b1;
      end
    end
  end

  assign tick_out = (on_a_reg & tick_a_in) | (on_b_reg & tick_b_in);
  assign on_b_out = on_b_reg;

endmodule

// ==== ccg_pkg.sv ====
package ccg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PROC_CLK_CTRL_ADDR  = 8'hFB;
  localparam logic [7:0] OSC_MODE_SEL_ADDR   = 8'hFC;
  localparam logic [7:0] STANDBY_CMD_ADDR    = 8'hFD;

  localparam logic [7:0] PROC_CLK_CTRL_RESET = 8'h04;
  localparam logic [7:0] OSC_MODE_SEL_RESET  = 8'h00;

  // Processor clock control fields
  localparam int MAIN_OSC_STOP_BIT   = 7;
  localparam int FB_RES_DIS_BIT      = 6;
  localparam int CLK_STATUS_BIT      = 5;
  localparam int SRC_SEL_BIT         = 4;
  localparam int ZERO_BIT            = 3;
  localparam int DIV_SEL_HI          = 2;

  // Oscillation mode select field
  localparam int BYPASS_SEL_BIT      = 0;

  // Standby command fields
  localparam int HALT_CMD_BIT        = 0;
  localparam int STOP_CMD_BIT        = 1;

  // ----------------------------------------------------------------
  // Divider and switchover figures
  // ----------------------------------------------------------------
  localparam int DIV_STAGES          = 5;
  localparam logic [2:0] DIV_MAX_CODE = 3'h4;
  localparam int INSTR_CLOCKS        = 2;
  // Switchover delay counted in instructions of the current CPU clock, two CPU clocks each
  localparam logic [4:0] SWITCH_DELAY_CLKS = 5'h04;
  // Bypass write stretch: up to two oscillator periods
  localparam logic [1:0] STRETCH_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    CCG_RUN,
    CCG_HALT,
    CCG_STOP
  } ccg_mode_e;

endpackage

// ==== cpu_clock_generator_control_test.sv ====
`timescale 1ns/10ps
module cpu_clock_generator_control_test
  import ccg_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  logic       clk_in = 0, arst_n_in = 0, main_osc_tick_in = 0;
  logic       sub_osc_in = 0, wake_in = 0, wr_in = 0, rd_in = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, bit_mask_in = 0, rdata_out;
  logic       main_osc_enable_out, feedback_resistor_disable_out;
  logic       main_sys_tick_out, cpu_tick_out, cpu_run_out;
  logic       sub_periph_tick_out, halt_out, stop_out;
  logic [4:0] periph_tick_out;
  int         err_count = 0, checked = 0, g, n, p;
  typedef struct packed {logic w; logic [7:0] a, d, m, e;} ccg_row_s;
  // Register rows: write flag, address, data, mask, read-back
  ccg_row_s   rows [7] = '{
    '{1'b0, PROC_CLK_CTRL_ADDR, 8'h00, 8'h00, 8'h04},
    '{1'b0, OSC_MODE_SEL_ADDR, 8'h00, 8'h00, 8'h00},
    '{1'b0, 8'h00, 8'h00, 8'h00, 8'h00},
    '{1'b1, PROC_CLK_CTRL_ADDR, 8'h63, 8'hFF, 8'h43},
    '{1'b1, PROC_CLK_CTRL_ADDR, 8'h80, 8'h80, 8'hC3},
    '{1'b1, PROC_CLK_CTRL_ADDR, 8'h00, 8'h40, 8'h83},
    '{1'b1, PROC_CLK_CTRL_ADDR, 8'h04, 8'hFF, 8'h04}};

  ccg_clock_gen i_ccg_clock_gen (
    .clk_in(clk_in), .arst_n_in(arst_n_in),
    .main_osc_tick_in(main_osc_tick_in), .sub_osc_in(sub_osc_in),
    .wake_in(wake_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .bit_mask_in(bit_mask_in),
    .rdata_out(rdata_out), .main_osc_enable_out(main_osc_enable_out),
    .feedback_resistor_disable_out(feedback_resistor_disable_out),
    .main_sys_tick_out(main_sys_tick_out), .cpu_tick_out(cpu_tick_out),
    .cpu_run_out(cpu_run_out), .periph_tick_out(periph_tick_out),
    .sub_periph_tick_out(sub_periph_tick_out), .halt_out(halt_out),
    .stop_out(stop_out));

  // Clocks: system 50 MHz, subsystem free running and unrelated
  initial forever #10 clk_in = ~clk_in;
  initial forever #400 sub_osc_in = ~sub_osc_in;
  // Oscillator pulses only while enabled, as a stopped crystal would;
  // a resonator, not an external clock, so STOP and the stop bit are fine
  always @(posedge clk_in)
    main_osc_tick_in <= ~main_osc_tick_in & main_osc_enable_out;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task check(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    bit_mask_in <= m;
    wr_in <= 1;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge clk_in);
    rd_in <= 0;
    #1 check("rdata", rdata_out, e);
  endtask
  task wait_n(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // Clocks between two CPU ticks; the bound keeps a dead clock visible
  task gap(output int c);
    n = 0;
    while (cpu_tick_out !== 1'b1 && n < 999) begin
      wait_n(1);
      n++;
    end
    c = 0;
    do begin
      wait_n(1);
      c++;
    end while (cpu_tick_out !== 1'b1 && c < 999);
  endtask
  task count_sys(output int c);
    c = 0;
    p = 0;
    repeat (64) begin
      wait_n(1);
      c += (main_sys_tick_out === 1'b1);
      p += (periph_tick_out[2] === 1'b1);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1;
    // Mode register written only now, before peripherals matter;
    // a same-value write still loses one main clock period
    wait_n(8);
    count_sys(n);
    check("sys_ticks", n, 16);
    check("periph_div4", p, 4);
    wr(OSC_MODE_SEL_ADDR, 8'h00, 8'hFF);
    count_sys(g);
    check("stretch", g < n, 1);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].m);
      rd(rows[i].a, rows[i].e);
      check("fb_res", feedback_resistor_disable_out, rows[i].e[6]);
    end
    wr(PROC_CLK_CTRL_ADDR, 8'h84, 8'hFF);
    wait_n(20);
    check("osc_en", main_osc_enable_out, 1);
    $display("test registers done");
    // Oscillator tick every 2 clocks, halved main clock: 4 << code
    for (int c = 0; c <= 4; c++) begin
      wr(PROC_CLK_CTRL_ADDR, 8'(c), 8'hFF);
      if (c == 0) begin
        gap(g);
        check("old_gap", g, 64);
      end
      wait_n(700);
      gap(g);
      check("cpu_gap", g, 4 << c);
    end
    wr(STANDBY_CMD_ADDR, 8'h02, 8'hFF);
    wait_n(4);
    check("stop", stop_out, 1);
    @(posedge clk_in) wake_in <= 1;
    wait_n(4);
    check("run", cpu_run_out, 1);
    @(posedge clk_in) wake_in <= 0;
    $display("test main clock done");
    // Source change keeps the ratio, as a combined change is barred
    wr(PROC_CLK_CTRL_ADDR, 8'h14, 8'hFF);
    rd(PROC_CLK_CTRL_ADDR, 8'h14);
    wait_n(900);
    rd(PROC_CLK_CTRL_ADDR, 8'h34);
    gap(g);
    check("sub_gap", g, 80);
    wr(PROC_CLK_CTRL_ADDR, 8'h94, 8'hFF);
    wait_n(10);
    check("osc_en", main_osc_enable_out, 0);
    wr(STANDBY_CMD_ADDR, 8'h02, 8'hFF);
    wait_n(4);
    check("stop", stop_out, 0);
    wr(STANDBY_CMD_ADDR, 8'h01, 8'hFF);
    wait_n(4);
    check("halt", halt_out, 1);
    n = 0;
    repeat (100) begin
      wait_n(1);
      n += (sub_periph_tick_out === 1'b1);
    end
    check("sub_ticks", n > 1, 1);
    @(posedge clk_in) wake_in <= 1;
    wait_n(4);
    check("run", cpu_run_out, 1);
    @(posedge clk_in) wake_in <= 0;
    $display("test subsystem done");
    // Second reset in mid-run
    @(posedge clk_in) arst_n_in <= 0;
    wait_n(3);
    check("osc_en", main_osc_enable_out, 0);
    @(posedge clk_in) arst_n_in <= 1;
    rd(PROC_CLK_CTRL_ADDR, 8'h04);
    rd(OSC_MODE_SEL_ADDR, 8'h00);
    // Bypass set straight after release, as software should
    wr(OSC_MODE_SEL_ADDR, 8'h01, 8'hFF);
    rd(OSC_MODE_SEL_ADDR, 8'h01);
    wait_n(200);
    gap(g);
    check("bypass_gap", g, 32);
    $display("test reset done");
    print_verdict();
  end

  // Watchdog: about nine times the expected run of about 5400 cycles
  initial begin
    #1_000_000;
    err_count++;
    print_verdict();
  end
endmodule
